// File: core/usfe_regs.svh
// Purpose: register map, field positions and reset values of the frame engine
// Assumes: plain register port with a 3-bit address
// Notes:   definitions only
`ifndef USFE_REGS_SVH
`define USFE_REGS_SVH

`define USFE_ADDR_W       3
`define USFE_OFF_DATA     3'h0
`define USFE_OFF_CSA      3'h1
`define USFE_OFF_CSB      3'h2
`define USFE_OFF_CSC      3'h3
`define USFE_OFF_BAUD     3'h4

// Status register A
`define USFE_CSA_RXC      7
`define USFE_CSA_TXC      6
`define USFE_CSA_TXE      5

// Control register B
`define USFE_CSB_TX_COMPLETE_IRQ_EN    6
`define USFE_CSB_TXEIE    5
`define USFE_CSB_RX_ENABLE     4
`define USFE_CSB_TX_ENABLE     3
`define USFE_CSB_TX9      0

// Control register C
`define USFE_CSC_SIZE_LO  0
`define USFE_CSC_SIZE_HI  2
`define USFE_CSC_STOP2    3
`define USFE_CSC_PODD     4
`define USFE_CSC_PEN      5
`define USFE_CSC_SYNC     6

`define USFE_SIZE_NINE    3'h7
`define USFE_SIZE_EIGHT   4'h8
`define USFE_SIZE_BASE    4'h5
`define USFE_CSC_RST      8'h03
`define USFE_BAUD_RST     8'h0F
`define USFE_FRAME_W      13
`define USFE_DATA_W       9

`endif

// File: core/usfe_pkg.sv
// Purpose: shared types of the frame engine
// Assumes: nothing
// Notes:   constants live in usfe_regs.svh
package usfe_pkg;
    typedef logic [7:0] usfe_byte_t;
    typedef logic [2:0] usfe_addr_t;
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_BITS
    } usfe_rx_state_t;
endpackage : usfe_pkg

// File: core/usfe_bit_timer.sv
// Purpose: bit tick source, divided clock or transfer clock edge
// Assumes: divisor+1 clock cycles per bit in asynchronous mode
// Notes:   restart with half set lands the first tick mid-bit
module usfe_bit_timer #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         sync_mode,
    input  wire logic         xfer_edge,
    input  wire logic         restart,
    input  wire logic         half,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
        end else if (restart) begin
            cnt_reg <= half ? (divisor >> 1) : divisor;
        end else if (cnt_reg == '0) begin
            cnt_reg <= divisor;
        end else begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // External clock replaces the divider entirely
    assign tick = sync_mode ? xfer_edge : ((cnt_reg == '0) && !restart);
endmodule : usfe_bit_timer

// File: core/usfe_frame_engine.sv
// Purpose: transmit and receive framing with data and control/status registers
// Assumes: inputs synchronous to clk; CPU masks interrupts globally
// Notes:   receive error flags and parity check are not built here
// Overview of operation
// - Empty flag tracks transmit buffer occupancy
// - Empty interrupt requested while enabled and empty
// - Data register write clears empty flag
// - Complete flag set after frame, buffer empty
// - Complete flag cleared by ack or one
// - Complete interrupt requested from flag and enable
// - Parity inserted between data and stop
// - Disable waits for shifter and buffer empty
// - Output pin released once transmitter disabled
// - Receive enable takes over input pin
// - Synchronous mode uses external transfer clock
// - Valid start bit begins frame sampling
// - Frame ends at first stop bit
// - First stop bit moves frame to buffer
// - Start low, data LSB first, stops high
// - Parity is xor, inverted for odd
// - Shifter loads when idle or after stop
// - Parity type selects odd or even
`include "usfe_regs.svh"

module usfe_frame_engine #(
    parameter int BAUD_W = 8
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire usfe_pkg::usfe_addr_t addr,
    input  wire usfe_pkg::usfe_byte_t wdata,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output usfe_pkg::usfe_byte_t     rdata,
    input  wire logic                rxd_in,
    input  wire logic                sync_xfer_clock,
    output logic                     txd_out,
    output logic                     txd_oe,
    output logic                     rxd_override,
    output logic                     irq_tx_empty,
    output logic                     irq_tx_complete,
    input  wire logic                irq_tx_complete_ack
);
    import usfe_pkg::*;

    // Data bit count from the size code; unused codes mean eight
    function automatic logic [3:0] data_bits(input logic [2:0] sel);
        logic [3:0] n;
        n = `USFE_SIZE_EIGHT;
        if (sel == `USFE_SIZE_NINE) begin
            n = 4'h9;
        end else if (sel[2] == 1'b0) begin
            n = `USFE_SIZE_BASE + {2'b00, sel[1:0]};
        end
        return n;
    endfunction : data_bits

    // Whole frame, bit 0 first on the line
    function automatic logic [`USFE_FRAME_W-1:0] build_frame(
        input logic [`USFE_DATA_W-1:0] d,
        input logic [3:0]              n,
        input logic                    pen,
        input logic                    podd
    );
        logic [`USFE_FRAME_W-1:0] f;
        logic                     par;
        f   = '1;
        par = podd;
        f[0] = 1'b0;
        for (int i = 0; i < `USFE_DATA_W; i++) begin
            if (i < int'(n)) begin
                f[i+1] = d[i];
                par    = par ^ d[i];
            end
        end
        if (pen) begin
            f[n+1] = par;
        end
        return f;
    endfunction : build_frame

    usfe_byte_t                csb_reg;
    usfe_byte_t                csc_reg;
    logic [BAUD_W-1:0]         baud_reg;
    logic [`USFE_DATA_W-1:0]   tx_buf_reg;
    logic                      tx_full_reg;
    logic                      tx_busy_reg;
    logic                      tx_on_reg;
    logic                      txc_reg;
    logic [`USFE_FRAME_W-1:0]  tx_shift_reg;
    logic [3:0]                tx_left_reg;
    usfe_rx_state_t            rx_state_reg;
    logic [`USFE_DATA_W-1:0]   rx_shift_reg;
    logic [3:0]                rx_cnt_reg;
    usfe_byte_t                rx_buf_reg;
    logic                      rx_full_reg;
    usfe_byte_t                rdata_reg;
    logic                      xck_prev_reg;

    logic       wr_data, rd_data, wr_csa, sync_mode, pen, podd, stop2;
    logic [3:0] nbits, frame_len, rx_stop_idx;
    logic       tx_tick, rx_tick, tx_last, tx_go, rx_begin, rx_store;

    assign wr_data     = wr_en && (addr == `USFE_OFF_DATA);
    assign rd_data     = rd_en && (addr == `USFE_OFF_DATA);
    assign wr_csa      = wr_en && (addr == `USFE_OFF_CSA);
    assign sync_mode   = csc_reg[`USFE_CSC_SYNC];
    assign pen         = csc_reg[`USFE_CSC_PEN];
    assign podd        = csc_reg[`USFE_CSC_PODD];
    assign stop2       = csc_reg[`USFE_CSC_STOP2];
    assign nbits       = data_bits(csc_reg[`USFE_CSC_SIZE_HI:`USFE_CSC_SIZE_LO]);
    assign frame_len   = nbits + {3'b000, pen} + {3'b000, stop2} + 4'h2;
    // stop index sits after data and parity
    assign rx_stop_idx = nbits + {3'b000, pen};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xck_prev_reg <= 1'b0;
        end else begin
            xck_prev_reg <= sync_xfer_clock;
        end
    end

    // transmit on rising, sample on falling edge
    usfe_bit_timer #(.W(BAUD_W)) u_tx_timer (
        .clk       (clk),
        .reset_n   (reset_n),
        .sync_mode (sync_mode),
        .xfer_edge (sync_xfer_clock && !xck_prev_reg),
        .restart   (tx_go && !tx_busy_reg),
        .half      (1'b0),
        .divisor   (baud_reg),
        .tick      (tx_tick)
    );

    usfe_bit_timer #(.W(BAUD_W)) u_rx_timer (
        .clk       (clk),
        .reset_n   (reset_n),
        .sync_mode (sync_mode),
        .xfer_edge (!sync_xfer_clock && xck_prev_reg),
        .restart   (rx_begin && !sync_mode),
        .half      (1'b1),
        .divisor   (baud_reg),
        .tick      (rx_tick)
    );

    // Control registers; ninth bit is written through register B
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            csb_reg  <= 8'h00;
            csc_reg  <= `USFE_CSC_RST;
            baud_reg <= BAUD_W'(`USFE_BAUD_RST);
        end else if (wr_en) begin
            if (addr == `USFE_OFF_CSB) begin
                csb_reg <= wdata;
            end
            if (addr == `USFE_OFF_CSC) begin
                csc_reg <= wdata;
            end
            if (addr == `USFE_OFF_BAUD) begin
                baud_reg <= BAUD_W'(wdata);
            end
        end
    end

    // ninth bit captured with the low byte
    // a write fills the buffer, winning over the move
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buf_reg  <= '0;
            tx_full_reg <= 1'b0;
        end else if (wr_data) begin
            tx_buf_reg  <= {csb_reg[`USFE_CSB_TX9], wdata};
            tx_full_reg <= 1'b1;
        end else if (tx_go) begin
            tx_full_reg <= 1'b0;
        end
    end

    // stays on while shifter or buffer hold data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_on_reg <= 1'b0;
        end else if (csb_reg[`USFE_CSB_TX_ENABLE]) begin
            tx_on_reg <= 1'b1;
        end else if (!tx_busy_reg && !tx_full_reg) begin
            tx_on_reg <= 1'b0;
        end
    end

    // load when idle or on the last stop tick
    assign tx_last = tx_busy_reg && tx_tick && (tx_left_reg == 4'h1);
    assign tx_go   = tx_on_reg && tx_full_reg && (!tx_busy_reg || tx_last);

    // Idle shifter holds ones so the line rests high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_shift_reg <= '1;
            tx_left_reg  <= 4'h0;
            tx_busy_reg  <= 1'b0;
        end else if (tx_go) begin
            tx_shift_reg <= build_frame(tx_buf_reg, nbits, pen, podd);
            tx_left_reg  <= frame_len;
            tx_busy_reg  <= 1'b1;
        end else if (tx_busy_reg && tx_tick) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[`USFE_FRAME_W-1:1]};
            tx_left_reg  <= tx_left_reg - 4'h1;
            tx_busy_reg  <= !tx_last;
        end
    end

    // set wins over ack and one-write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txc_reg <= 1'b0;
        end else if (tx_last && !tx_full_reg) begin
            txc_reg <= 1'b1;
        end else if (irq_tx_complete_ack || (wr_csa && wdata[`USFE_CSA_TXC])) begin
            txc_reg <= 1'b0;
        end
    end

    // pin handed back once really off
    assign txd_out = tx_shift_reg[0];
    assign txd_oe  = tx_on_reg;
    // input pin taken over by the receiver
    assign rxd_override = csb_reg[`USFE_CSB_RX_ENABLE];

    assign irq_tx_empty    = csb_reg[`USFE_CSB_TXEIE] && !tx_full_reg;
    assign irq_tx_complete = csb_reg[`USFE_CSB_TX_COMPLETE_IRQ_EN] && txc_reg;

    // async waits mid start bit, sync starts on sample
    assign rx_begin = rxd_override && (rx_state_reg == RX_IDLE) && !rxd_in
                      && (!sync_mode || rx_tick);
    assign rx_store = (rx_state_reg == RX_BITS) && rx_tick && (rx_cnt_reg == rx_stop_idx);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 4'h0;
            rx_shift_reg <= '0;
        end else if (!rxd_override) begin
            rx_state_reg <= RX_IDLE;
        end else begin
            unique case (rx_state_reg)
                RX_IDLE: begin
                    if (rx_begin) begin
                        rx_state_reg <= sync_mode ? RX_BITS : RX_START;
                        rx_cnt_reg   <= 4'h0;
                        rx_shift_reg <= '0;
                    end
                end
                RX_START: begin
                    // Glitch shorter than half a bit is dropped
                    if (rx_tick) begin
                        rx_state_reg <= rxd_in ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (rx_tick) begin
                        if (rx_cnt_reg < nbits) begin
                            rx_shift_reg[rx_cnt_reg] <= rxd_in;
                        end
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_store) begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // buffer filled at first stop; arrival beats the read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buf_reg  <= 8'h00;
            rx_full_reg <= 1'b0;
        end else if (!rxd_override) begin
            rx_full_reg <= 1'b0;
        end else if (rx_store) begin
            rx_buf_reg  <= rx_shift_reg[7:0];
            rx_full_reg <= 1'b1;
        end else if (rd_data) begin
            rx_full_reg <= 1'b0;
        end
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (!rd_en) begin
            rdata_reg <= 8'h00;
        end else begin
            unique case (addr)
                `USFE_OFF_DATA: rdata_reg <= rx_buf_reg;
                `USFE_OFF_CSA:  rdata_reg <= {rx_full_reg, txc_reg, !tx_full_reg, 5'b00000};
                `USFE_OFF_CSB:  rdata_reg <= csb_reg;
                `USFE_OFF_CSC:  rdata_reg <= csc_reg;
                `USFE_OFF_BAUD: rdata_reg <= 8'(baud_reg);
                default:        rdata_reg <= 8'h00;
            endcase
        end
    end
    assign rdata = rdata_reg;

    sequence s_tx_idle_load;
        tx_go && !tx_busy_reg;
    endsequence
    sequence s_tx_final_tick;
        tx_last && !tx_full_reg;
    endsequence

    property p_empty_clear;
        @(posedge clk) disable iff (!reset_n)
        wr_data |=> !irq_tx_empty && tx_full_reg;
    endproperty
    a_empty_clear: assert property (p_empty_clear) else $error("buffer not full after write");
    // Any register write may change the enable, so only quiet cycles count
    property p_empty_irq;
        @(posedge clk) disable iff (!reset_n)
        csb_reg[`USFE_CSB_TXEIE] && !tx_busy_reg && !tx_full_reg && !wr_en
            |=> irq_tx_empty;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("empty request missing");
    property p_txc_set;
        @(posedge clk) disable iff (!reset_n)
        s_tx_final_tick |=> txc_reg && txd_out && !tx_busy_reg;
    endproperty
    a_txc_set: assert property (p_txc_set) else $error("complete flag not set");
    property p_txc_clear;
        @(posedge clk) disable iff (!reset_n)
        irq_tx_complete_ack && !tx_last |=> !txc_reg;
    endproperty
    a_txc_clear: assert property (p_txc_clear) else $error("complete flag not cleared");
    property p_txc_irq;
        @(posedge clk) disable iff (!reset_n)
        s_tx_final_tick ##0 (csb_reg[`USFE_CSB_TX_COMPLETE_IRQ_EN] && !wr_en) |=> irq_tx_complete;
    endproperty
    a_txc_irq: assert property (p_txc_irq) else $error("complete request missing");
    property p_start_bit;
        @(posedge clk) disable iff (!reset_n)
        s_tx_idle_load |=> !txd_out && txd_oe;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not low");
    // Data buffered while off stays parked, so only a driven pin must stay driven
    property p_hold_on;
        @(posedge clk) disable iff (!reset_n)
        txd_oe && (tx_busy_reg || tx_full_reg) |=> txd_oe;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("pin released with data pending");
    property p_release;
        @(posedge clk) disable iff (!reset_n)
        !csb_reg[`USFE_CSB_TX_ENABLE] && !tx_busy_reg && !tx_full_reg && !wr_en |=> !txd_oe;
    endproperty
    a_release: assert property (p_release) else $error("pin still driven");
    property p_rx_store;
        @(posedge clk) disable iff (!reset_n)
        rx_store && rxd_override |=> rx_full_reg && (rx_state_reg == RX_IDLE);
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("frame not buffered");
endmodule : usfe_frame_engine

// File: testbench/usfe_peer.sv
// Purpose: remote serial peer, sends frames and decodes the device's frames
// Assumes: BIT clocks per bit, equal to divisor+1 of the device
// Notes:   decodes mid-bit on the falling clock to stay off the launch edge
module usfe_peer #(
    parameter int BIT = 8
) (
    input  wire logic       clk,
    input  wire logic       line_in,
    output logic            line_out,
    input  wire logic [3:0] nbits,
    input  wire logic       pen,
    output logic [8:0]      got_data,
    output logic            got_par,
    output logic            got_stop,
    output int              got_count
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        line_out  = 1'b1;
        got_count = 0;
        got_data  = '0;
        got_par   = 1'b0;
        got_stop  = 1'b0;
    end

    always begin : rx_side
        logic [8:0] d;
        @(negedge line_in);
        repeat (BIT / 2) @(negedge clk);
        if (line_in === 1'b0) begin
            d = '0;
            for (int i = 0; i < nbits; i++) begin
                repeat (BIT) @(negedge clk);
                d[i] = line_in;
            end
            if (pen) begin
                repeat (BIT) @(negedge clk);
                got_par = line_in;
            end
            repeat (BIT) @(negedge clk);
            got_stop  = line_in;
            got_data  = d;
            got_count = got_count + 1;
        end
    end

    task automatic put_bit(input logic v);
        @(posedge clk);
        line_out <= v;
        repeat (BIT - 1) @(posedge clk);
    endtask : put_bit

    // start low, data LSB first, high stops
    task automatic send(input logic [8:0] d, input int n, input logic p_on,
                        input logic p, input int stops);
        put_bit(1'b0);
        for (int i = 0; i < n; i++) put_bit(d[i]);
        if (p_on) put_bit(p);
        repeat (stops) put_bit(1'b1);
    endtask : send

    // Low pulse shorter than half a bit
    task automatic glitch();
        @(posedge clk);
        line_out <= 1'b0;
        repeat (2) @(posedge clk);
        line_out <= 1'b1;
    endtask : glitch
endmodule : usfe_peer

// File: testbench/testbench.sv
// Purpose: self-checking bench of the frame engine
// Assumes: asynchronous mode, divisor 7 gives 8 clocks per bit
// Notes:   transfer clock idles low; driven only in the synchronous receive case
`include "usfe_regs.svh"
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("FAIL %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import usfe_pkg::*;
    localparam int BIT = 8;
    logic       clk, reset_n, wr_en, rd_en, rxd_in, txd_out, txd_oe, rxd_override;
    logic       irq_tx_empty, irq_tx_complete, irq_tx_complete_ack, xfer_clk, line;
    usfe_addr_t addr;
    usfe_byte_t wdata, rdata, v;
    logic [3:0] nbits;
    logic       pen, got_par, got_stop;
    logic [8:0] got_data;
    int         got_count, fail_count, compares, seed;
    logic [2:0] sizes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, `USFE_SIZE_NINE};

    // Released pin floats to its pull-up
    assign line = txd_oe ? txd_out : 1'b1;

    usfe_frame_engine #(.BAUD_W(8)) uut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .rxd_in(rxd_in), .sync_xfer_clock(xfer_clk),
        .txd_out(txd_out), .txd_oe(txd_oe), .rxd_override(rxd_override),
        .irq_tx_empty(irq_tx_empty), .irq_tx_complete(irq_tx_complete),
        .irq_tx_complete_ack(irq_tx_complete_ack)
    );
    usfe_peer #(.BIT(BIT)) peer (
        .clk(clk), .line_in(line), .line_out(rxd_in), .nbits(nbits), .pen(pen),
        .got_data(got_data), .got_par(got_par), .got_stop(got_stop), .got_count(got_count)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [3:0] bits_of(input logic [2:0] sz);
        return (sz == `USFE_SIZE_NINE) ? 4'h9 : `USFE_SIZE_BASE + {1'b0, sz};
    endfunction : bits_of

    // xor of data, inverted for odd
    function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < n; i++) p ^= d[i];
        return p;
    endfunction : par_of

    function automatic logic [8:0] mask(input logic [8:0] d, input logic [3:0] n);
        return d & ((9'h001 << n) - 9'h001);
    endfunction : mask

    task automatic wr(input usfe_addr_t a, input usfe_byte_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input usfe_addr_t a, output usfe_byte_t d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic wait_frames(input int n);
        int t;
        t = 0;
        while (got_count < n && t < 4000) begin
            @(posedge clk);
            t++;
        end
        `CHK("frame wait", 1'b1, t < 4000)
    endtask : wait_frames

    task automatic tx_one(input logic [2:0] sz, input logic pe, input logic po,
                          input logic s2, input logic [8:0] d);
        wr(`USFE_OFF_CSC, {2'b00, pe, po, s2, sz});
        nbits = bits_of(sz);
        pen   = pe;
        wr(`USFE_OFF_CSB, 8'h28 | {7'h00, d[8]});
        wr(`USFE_OFF_DATA, d[7:0]);
    endtask : tx_one

    task automatic rx_check(input logic [8:0] e);
        int t;
        usfe_byte_t r;
        t = 0;
        r = '0;
        while (r[`USFE_CSA_RXC] !== 1'b1 && t < 400) begin
            rd(`USFE_OFF_CSA, r);
            t++;
        end
        `CHK("rx wait", 1'b1, t < 400)
        rd(`USFE_OFF_DATA, r);
        `CHK("rx data", e[7:0], r)
        rd(`USFE_OFF_CSA, r);
        `CHK("rx full cleared", 1'b0, r[`USFE_CSA_RXC])
    endtask : rx_check

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // Whole run is a few thousand cycles
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    initial begin : main
        int n0;
        time t_a;
        logic [8:0] d;
        logic [2:0] sz;
        logic pe, po, s2;
        seed = 32'h0AF2;
        reset_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        irq_tx_complete_ack = 1'b0;
        xfer_clk = 1'b0;
        nbits = 4'h8;
        pen = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1 `CHK("txd_oe", 1'b0, txd_oe)
        `CHK("txd idle", 1'b1, txd_out)
        rd(`USFE_OFF_CSA, v);
        `CHK("status a", 8'h20, v)
        rd(`USFE_OFF_CSC, v);
        `CHK("ctrl c", `USFE_CSC_RST, v)
        rd(`USFE_OFF_BAUD, v);
        `CHK("baud", `USFE_BAUD_RST, v)
        rd(3'h6, v);
        `CHK("unmapped", 8'h00, v)
        wr(`USFE_OFF_BAUD, 8'h07);
        wr(`USFE_OFF_CSB, 8'h28);
        #1 `CHK("empty irq", 1'b1, irq_tx_empty)
        wr(`USFE_OFF_CSB, 8'h08);
        #1 `CHK("empty irq masked", 1'b0, irq_tx_empty)
        for (int k = 0; k < 10; k++) begin
            d = 9'($random(seed));
            sz = sizes[k % 5];
            {pe, po, s2} = 3'($random(seed));
            n0 = got_count;
            tx_one(sz, pe, po, s2, d);
            #1 `CHK("empty irq after write", 1'b0, irq_tx_empty)
            wait_frames(n0 + 1);
            `CHK("tx data", mask(d, bits_of(sz)), got_data)
            if (pe) `CHK("tx parity", par_of(d, bits_of(sz), po), got_par)
            `CHK("tx stop", 1'b1, got_stop)
            repeat (2 * BIT + 2) @(posedge clk);
            rd(`USFE_OFF_CSA, v);
            `CHK("complete set", 8'h60, v)
            // empty flag position written as zero
            wr(`USFE_OFF_CSA, 8'h40);
            rd(`USFE_OFF_CSA, v);
            `CHK("complete cleared", 8'h20, v)
        end
        wr(`USFE_OFF_CSC, 8'h03);
        nbits = 4'h8;
        pen = 1'b0;
        wr(`USFE_OFF_CSB, 8'h48);
        n0 = got_count;
        wr(`USFE_OFF_DATA, 8'hA5);
        wr(`USFE_OFF_DATA, 8'h3C);
        rd(`USFE_OFF_CSA, v);
        `CHK("buffer held", 8'h00, v)
        wait_frames(n0 + 1);
        t_a = $time;
        `CHK("first byte", 9'h0A5, got_data)
        repeat (BIT) @(posedge clk);
        `CHK("no early complete", 1'b0, irq_tx_complete)
        wait_frames(n0 + 2);
        `CHK("second byte", 9'h03C, got_data)
        `CHK("frame spacing", 64'(10 * BIT * 10), $time - t_a)
        repeat (BIT + 2) @(posedge clk);
        `CHK("complete irq", 1'b1, irq_tx_complete)
        @(posedge clk) irq_tx_complete_ack <= 1'b1;
        @(posedge clk) irq_tx_complete_ack <= 1'b0;
        #1 `CHK("ack clears", 1'b0, irq_tx_complete)
        wr(`USFE_OFF_CSB, 8'h08);
        n0 = got_count;
        wr(`USFE_OFF_DATA, 8'h96);
        wr(`USFE_OFF_CSB, 8'h00);
        #1 `CHK("pin held", 1'b1, txd_oe)
        wait_frames(n0 + 1);
        `CHK("last byte", 9'h096, got_data)
        repeat (BIT + 2) @(posedge clk);
        `CHK("pin released", 1'b0, txd_oe)
        wr(`USFE_OFF_CSB, 8'h10);
        #1 `CHK("rx owns pin", 1'b1, rxd_override)
        wr(`USFE_OFF_CSC, 8'h0B);
        peer.glitch();
        repeat (2 * BIT) @(posedge clk);
        rd(`USFE_OFF_CSA, v);
        `CHK("glitch ignored", 8'h60, v)
        // Second stop selected, peer sends one: receiver must not wait for it
        for (int k = 0; k < 5; k++) begin
            d = 9'($random(seed));
            sz = sizes[k];
            {pe, po} = 2'($random(seed));
            wr(`USFE_OFF_CSC, {2'b00, pe, po, 1'b1, sz});
            fork
                peer.send(d, bits_of(sz), pe, par_of(d, bits_of(sz), po), 1);
                rx_check(mask(d, bits_of(sz)));
            join
        end
        wr(`USFE_OFF_CSC, 8'h63);
        d = 9'($random(seed));
        fork
            peer.send(d, 8, 1'b1, par_of(d, 4'h8, 1'b0), 1);
            rx_check(mask(d, 4'h8));
            repeat (24) begin
                @(posedge clk);
                xfer_clk <= ~xfer_clk;
                repeat (BIT / 2 - 1) @(posedge clk);
            end
        join
        end_of_test();
    end
endmodule : testbench
